/* hdl/dfs_regs.vh */
`ifndef DFS_REGS_VH
`define DFS_REGS_VH

// ----------------------------------------------------------------------------
// Status register addresses (read side)
// ----------------------------------------------------------------------------
`define DFS_ST_INJECTOR      4'h0
`define DFS_ST_UNUSED        4'h1
`define DFS_ST_RELAY_ONE     4'h2
`define DFS_ST_RELAY_TWO     4'h3
`define DFS_ST_TACHO         4'h4
`define DFS_ST_LAMP          4'h5
`define DFS_ST_IGN_PREDRV    4'h6
`define DFS_ST_HTR_PREDRV    4'h7
`define DFS_ST_ON_STATE      4'he

// ----------------------------------------------------------------------------
// Control and configuration register addresses (write side)
// ----------------------------------------------------------------------------
`define DFS_CT_MAIN_ONOFF    4'h0
`define DFS_CT_HTR_CONFIG    4'h7
`define DFS_CT_IGN_CONFIG    4'h8
`define DFS_CT_LS_SINK_EN    4'ha

// ----------------------------------------------------------------------------
// Fault byte field positions
// ----------------------------------------------------------------------------
`define DFS_FB_GLOBAL        7
`define DFS_FB_OPEN_LOAD     3
`define DFS_FB_OVERCURRENT   2
`define DFS_FB_OVERTEMP      1
`define DFS_FB_SHORT_GND     0

// ----------------------------------------------------------------------------
// On/off bit positions, shared by control and indicator bytes
// ----------------------------------------------------------------------------
`define DFS_ON_INJECTOR      7
`define DFS_ON_RELAY_ONE     5
`define DFS_ON_RELAY_TWO     4
`define DFS_ON_LAMP          3
`define DFS_ON_IGNITION      2
`define DFS_ON_HEATER        0

// ----------------------------------------------------------------------------
// Pre-driver configuration field positions
// ----------------------------------------------------------------------------
`define DFS_CF_IGBT_MODE     7
`define DFS_CF_LOAD_SINK     4
`define DFS_CF_AND_SELECT    2
`define DFS_CF_WRITE_MASK    8'hd7

// ----------------------------------------------------------------------------
// Low-side driver indices in the driver vectors
// ----------------------------------------------------------------------------
`define DFS_LS_INJECTOR      0
`define DFS_LS_RELAY_ONE     1
`define DFS_LS_RELAY_TWO     2
`define DFS_LS_TACHO         3
`define DFS_LS_LAMP          4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DFS_RST_STATUS       8'h00
`define DFS_RST_MAIN_ONOFF   8'h00
`define DFS_RST_HTR_CONFIG   8'h10
`define DFS_RST_IGN_CONFIG   8'h80
`define DFS_RST_LS_SINK      5'h1f
`define DFS_RST_RDATA        8'h00

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define DFS_SYNC_STAGES      2

`endif

/* hdl/dfs_status_bank.v */
// Operation
// R01 - Global bit is OR of four flags
// R02 - Flags: open load, overcurrent, overtemp, short
// R03 - Disabled open-load detection holds flag zero
// R04 - Tachometer byte has no short-to-ground flag
// R05 - Fault bytes at 0,2,3,4,5; reset zero
// R06 - Address 14 mirrors actual output on/off states
// R07 - Host drives ignition control pin directly
// R08 - Host drives heater control pin directly
// R09 - Floating control input reads as low
// R10 - Ignition pre-driver resets to ignition mode
// R11 - Heater pre-driver resets to gate mode
// R12 - Ignition feedback and sense set fault flags
// R13 - Heater feedback and sense report faults
// R14 - Gate is pin OR bit, AND if selected
// R15 - Cleared sink enable forces open-load zero
// R16 - Open load when off, short when on
// R17 - Unused bits and addresses read zero, reads harmless
// R18 - Flags follow live condition, not latched
`timescale 1ns/10ps
`include "dfs_regs.vh"

module dfs_status_bank #(
    parameter LS_COUNT = 5
) (
    input  wire                i_core_clk,
    input  wire                i_rstn,
    input  wire                i_reg_wr,
    input  wire [3:0]          i_reg_addr,
    input  wire [7:0]          i_reg_wdata,
    input  wire [3:0]          i_stat_addr,
    output reg  [7:0]          o_stat_rdata,
    input  wire [LS_COUNT-1:0] i_ls_open_load,
    input  wire [LS_COUNT-1:0] i_ls_overcurrent,
    input  wire [LS_COUNT-1:0] i_ls_overtemp,
    input  wire [LS_COUNT-1:0] i_ls_short_gnd,
    input  wire [LS_COUNT-1:0] i_ls_on_state,
    input  wire                i_ignition_control_input,
    input  wire                i_heater_control_input,
    input  wire                i_ignition_drain_feedback,
    input  wire                i_heater_drain_feedback,
    input  wire                i_ignition_sense_over,
    input  wire                i_heater_sense_over,
    output reg                 o_ignition_gate_output,
    output reg                 o_heater_gate_output,
    output reg                 o_ignition_igbt_mode,
    output reg                 o_heater_igbt_mode,
    output reg                 o_ignition_sink_en,
    output reg                 o_heater_sink_en,
    output reg  [LS_COUNT-1:0] o_ls_sink_en
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------

    // Builds one fault byte: global bit over the four flags, flags below.
    function [7:0] fault_byte;
        input opn;
        input ovc;
        input hot;
        input gnd;
        begin
            fault_byte                      = 8'h00;
            fault_byte[`DFS_FB_OPEN_LOAD]   = opn;                      // see R02
            fault_byte[`DFS_FB_OVERCURRENT] = ovc;                      // see R02
            fault_byte[`DFS_FB_OVERTEMP]    = hot;                      // see R02
            fault_byte[`DFS_FB_SHORT_GND]   = gnd;                      // see R02
            fault_byte[`DFS_FB_GLOBAL]      = opn | ovc | hot | gnd;    // see R01
        end
    endfunction

    // Combines pin and control bit, OR by default and AND when selected.
    function gate_logic;
        input pin;
        input ctl;
        input and_sel;
        begin
            gate_logic = and_sel ? (pin & ctl) : (pin | ctl);        // see R14
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------

    localparam SYNC_W = 5 * LS_COUNT + 6;    // All pins that cross into the core.

    wire [SYNC_W-1:0] raw_pins;              // Pins as they arrive.
    wire [SYNC_W-1:0] sync_pins;             // Pins after two flip-flops.

    assign raw_pins = {i_ls_open_load, i_ls_overcurrent, i_ls_overtemp,
                       i_ls_short_gnd, i_ls_on_state,
                       i_ignition_control_input, i_heater_control_input,
                       i_ignition_drain_feedback, i_heater_drain_feedback,
                       i_ignition_sense_over, i_heater_sense_over};

    // Synchroniser resets to zero, so an idle or floating pin reads low.
    dfs_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (raw_pins),
        .o_sync     (sync_pins)
    );

    wire [LS_COUNT-1:0] ls_opn_s;    // Low-side open-load comparators.
    wire [LS_COUNT-1:0] ls_ovc_s;    // Low-side overcurrent comparators.
    wire [LS_COUNT-1:0] ls_hot_s;    // Low-side overtemperature sensors.
    wire [LS_COUNT-1:0] ls_gnd_s;    // Low-side short-to-ground comparators.
    wire [LS_COUNT-1:0] ls_on_s;     // Low-side actual output states.
    wire                ign_pin_s;   // Ignition control pin.
    wire                htr_pin_s;   // Heater control pin.
    wire                ign_fb_s;    // Ignition drain above threshold.
    wire                htr_fb_s;    // Heater drain above threshold.
    wire                ign_cs_s;    // Ignition sense voltage above threshold.
    wire                htr_cs_s;    // Heater sense voltage above threshold.

    assign {ls_opn_s, ls_ovc_s, ls_hot_s, ls_gnd_s, ls_on_s,
            ign_pin_s, htr_pin_s, ign_fb_s, htr_fb_s,
            ign_cs_s, htr_cs_s} = sync_pins;

    // ------------------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------------------

    reg [7:0]          main_onoff_reg;   // Software on/off command bits.
    reg [7:0]          htr_config_reg;   // Heater pre-driver configuration.
    reg [7:0]          ign_config_reg;   // Ignition pre-driver configuration.
    reg [LS_COUNT-1:0] ls_sink_en_reg;   // Low-side open-load sense enables.

    // Software writes; each pre-driver leaves reset in its default mode.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            main_onoff_reg <= `DFS_RST_MAIN_ONOFF;
            htr_config_reg <= `DFS_RST_HTR_CONFIG;   // see R11
            ign_config_reg <= `DFS_RST_IGN_CONFIG;   // see R10
            ls_sink_en_reg <= `DFS_RST_LS_SINK;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `DFS_CT_MAIN_ONOFF: begin
                    main_onoff_reg <= i_reg_wdata;
                end
                `DFS_CT_HTR_CONFIG: begin
                    htr_config_reg <= i_reg_wdata & `DFS_CF_WRITE_MASK;
                end
                `DFS_CT_IGN_CONFIG: begin
                    ign_config_reg <= i_reg_wdata & `DFS_CF_WRITE_MASK;
                end
                `DFS_CT_LS_SINK_EN: begin
                    ls_sink_en_reg <= i_reg_wdata[LS_COUNT-1:0];
                end
                default: begin
                    // Other addresses are ignored.
                    main_onoff_reg <= main_onoff_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pre-driver outputs and mode outputs
    // ------------------------------------------------------------------------

    wire ign_gate_next;   // Next ignition gate level.
    wire htr_gate_next;   // Next heater gate level.

    assign ign_gate_next = gate_logic(ign_pin_s, main_onoff_reg[`DFS_ON_IGNITION],
                                      ign_config_reg[`DFS_CF_AND_SELECT]);   // see R14
    assign htr_gate_next = gate_logic(htr_pin_s, main_onoff_reg[`DFS_ON_HEATER],
                                      htr_config_reg[`DFS_CF_AND_SELECT]);   // see R14

    // Gate and mode outputs are registered; a lost pin reads low and so
    // cannot turn a gate on while the control bit is clear.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ignition_gate_output <= 1'h0;                          // see R09
            o_heater_gate_output   <= 1'h0;                          // see R09
            o_ignition_igbt_mode   <= 1'h1;                          // see R10
            o_heater_igbt_mode     <= 1'h0;                          // see R11
            o_ignition_sink_en     <= 1'h0;
            o_heater_sink_en       <= 1'h1;
            o_ls_sink_en           <= `DFS_RST_LS_SINK;
        end else begin
            o_ignition_gate_output <= ign_gate_next;
            o_heater_gate_output   <= htr_gate_next;
            o_ignition_igbt_mode   <= ign_config_reg[`DFS_CF_IGBT_MODE];   // see R10
            o_heater_igbt_mode     <= htr_config_reg[`DFS_CF_IGBT_MODE];   // see R11
            o_ignition_sink_en     <= ign_config_reg[`DFS_CF_LOAD_SINK];
            o_heater_sink_en       <= htr_config_reg[`DFS_CF_LOAD_SINK];
            o_ls_sink_en           <= ls_sink_en_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Fault condition qualification
    // ------------------------------------------------------------------------

    wire [LS_COUNT-1:0] ls_opn_q;   // Low-side open load, qualified.
    wire                ign_opn_q;  // Ignition open load, qualified.
    wire                htr_opn_q;  // Heater open load, qualified.
    wire                ign_ovc_q;  // Ignition short-to-battery or overcurrent.
    wire                htr_ovc_q;  // Heater short-to-battery or overcurrent.

    // Open load counts only with the sink enabled and the output off.
    assign ls_opn_q  = ls_opn_s & ls_sink_en_reg & ~ls_on_s;             // see R03 R15 R16
    assign ign_opn_q = ign_config_reg[`DFS_CF_LOAD_SINK] & ~o_ignition_gate_output
                       & ~ign_fb_s;                                      // see R15 R16
    assign htr_opn_q = htr_config_reg[`DFS_CF_LOAD_SINK] & ~o_heater_gate_output
                       & ~htr_fb_s;                                      // see R15 R16

    // Drain high while on is a short to battery; sense adds overcurrent.
    assign ign_ovc_q = (o_ignition_gate_output & ign_fb_s) | ign_cs_s;   // see R12 R16
    assign htr_ovc_q = (o_heater_gate_output & htr_fb_s) | htr_cs_s;     // see R13 R16

    // ------------------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------------------

    reg [7:0] inj_status_reg;    // Injector fault byte.
    reg [7:0] rly1_status_reg;   // Relay one fault byte.
    reg [7:0] rly2_status_reg;   // Relay two fault byte.
    reg [7:0] tach_status_reg;   // Tachometer fault byte.
    reg [7:0] lamp_status_reg;   // Lamp fault byte.
    reg [7:0] ign_status_reg;    // Ignition pre-driver fault byte.
    reg [7:0] htr_status_reg;    // Heater pre-driver fault byte.
    reg [7:0] on_state_reg;      // Actual on/off indicator byte.

    // Bytes follow the live conditions every cycle and hold no history.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            inj_status_reg  <= `DFS_RST_STATUS;                      // see R05
            rly1_status_reg <= `DFS_RST_STATUS;                      // see R05
            rly2_status_reg <= `DFS_RST_STATUS;                      // see R05
            tach_status_reg <= `DFS_RST_STATUS;                      // see R05
            lamp_status_reg <= `DFS_RST_STATUS;                      // see R05
            ign_status_reg  <= `DFS_RST_STATUS;
            htr_status_reg  <= `DFS_RST_STATUS;
            on_state_reg    <= `DFS_RST_STATUS;
        end else begin
            inj_status_reg  <= fault_byte(ls_opn_q[`DFS_LS_INJECTOR],
                                          ls_ovc_s[`DFS_LS_INJECTOR],
                                          ls_hot_s[`DFS_LS_INJECTOR],
                                          ls_gnd_s[`DFS_LS_INJECTOR]);  // see R18
            rly1_status_reg <= fault_byte(ls_opn_q[`DFS_LS_RELAY_ONE],
                                          ls_ovc_s[`DFS_LS_RELAY_ONE],
                                          ls_hot_s[`DFS_LS_RELAY_ONE],
                                          ls_gnd_s[`DFS_LS_RELAY_ONE]); // see R18
            rly2_status_reg <= fault_byte(ls_opn_q[`DFS_LS_RELAY_TWO],
                                          ls_ovc_s[`DFS_LS_RELAY_TWO],
                                          ls_hot_s[`DFS_LS_RELAY_TWO],
                                          ls_gnd_s[`DFS_LS_RELAY_TWO]); // see R18
            // The tachometer has no short sensing, so its bit 0 stays zero.
            tach_status_reg <= fault_byte(ls_opn_q[`DFS_LS_TACHO],
                                          ls_ovc_s[`DFS_LS_TACHO],
                                          ls_hot_s[`DFS_LS_TACHO],
                                          1'h0);                        // see R04
            lamp_status_reg <= fault_byte(ls_opn_q[`DFS_LS_LAMP],
                                          ls_ovc_s[`DFS_LS_LAMP],
                                          ls_hot_s[`DFS_LS_LAMP],
                                          ls_gnd_s[`DFS_LS_LAMP]);      // see R18
            ign_status_reg  <= fault_byte(ign_opn_q, ign_ovc_q, 1'h0, 1'h0); // see R12
            htr_status_reg  <= fault_byte(htr_opn_q, htr_ovc_q, 1'h0, 1'h0); // see R13
            // Indicators use the same bit places as the on/off control byte.
            on_state_reg <= 8'h00;
            on_state_reg[`DFS_ON_INJECTOR]  <= ls_on_s[`DFS_LS_INJECTOR];   // see R06
            on_state_reg[`DFS_ON_RELAY_ONE] <= ls_on_s[`DFS_LS_RELAY_ONE];  // see R06
            on_state_reg[`DFS_ON_RELAY_TWO] <= ls_on_s[`DFS_LS_RELAY_TWO];  // see R06
            on_state_reg[`DFS_ON_LAMP]      <= ls_on_s[`DFS_LS_LAMP];       // see R06
            on_state_reg[`DFS_ON_IGNITION]  <= o_ignition_gate_output;      // see R06
            on_state_reg[`DFS_ON_HEATER]    <= o_heater_gate_output;        // see R06
        end
    end

    // ------------------------------------------------------------------------
    // Status read port
    // ------------------------------------------------------------------------

    reg [7:0] rdata_next;   // Selected status byte.

    // Pure selection: reading never disturbs any flag.
    always @* begin
        case (i_stat_addr)
            `DFS_ST_INJECTOR:   rdata_next = inj_status_reg;   // see R05
            `DFS_ST_RELAY_ONE:  rdata_next = rly1_status_reg;  // see R05
            `DFS_ST_RELAY_TWO:  rdata_next = rly2_status_reg;  // see R05
            `DFS_ST_TACHO:      rdata_next = tach_status_reg;  // see R05
            `DFS_ST_LAMP:       rdata_next = lamp_status_reg;  // see R05
            `DFS_ST_IGN_PREDRV: rdata_next = ign_status_reg;
            `DFS_ST_HTR_PREDRV: rdata_next = htr_status_reg;
            `DFS_ST_ON_STATE:   rdata_next = on_state_reg;     // see R06
            default:            rdata_next = 8'h00;            // see R17
        endcase
    end

    // Read data is registered one cycle after the address.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_stat_rdata <= `DFS_RST_RDATA;
        end else begin
            o_stat_rdata <= rdata_next;   // see R17
        end
    end

endmodule

/* hdl/dfs_sync.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Two-stage synchroniser for a vector of unrelated level signals.
// ----------------------------------------------------------------------------
module dfs_sync #(
    parameter WIDTH = 8
) (
    input  wire             i_core_clk,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_reg;   // First stage, read only by the second stage.
    reg [WIDTH-1:0] sync_reg;   // Second stage, safe for logic to read.

    // Both stages clear to zero so that every pin reads low after reset.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= {WIDTH{1'h0}};
            sync_reg <= {WIDTH{1'h0}};
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule

/* hdl/dfs_top_note.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// No logic here; the bank and its synchroniser have files of their own.
// ----------------------------------------------------------------------------

/* verif/dfs_host_model.sv */
`timescale 1ns/10ps

// Host side of the two pre-driver control pins.
// A released pin falls to the pulldown level, never to a stale value.
module dfs_host_model (
    input  wire i_ign_drive,
    input  wire i_ign_level,
    input  wire i_htr_drive,
    input  wire i_htr_level,
    output wire o_ign_pin,
    output wire o_htr_pin
);
    assign o_ign_pin = i_ign_drive ? i_ign_level : 1'h0;
    assign o_htr_pin = i_htr_drive ? i_htr_level : 1'h0;
endmodule

/* verif/dfs_status_bank_checker.sv */
`timescale 1ns/10ps

// Watches the read port and configuration outputs.
module dfs_status_bank_checker #(
    parameter LS_COUNT = 5
) (
    input wire                i_core_clk,
    input wire                i_rstn,
    input wire                i_reg_wr,
    input wire [3:0]          i_reg_addr,
    input wire [7:0]          i_reg_wdata,
    input wire [3:0]          i_stat_addr,
    input wire [7:0]          o_stat_rdata,
    input wire                o_ignition_igbt_mode,
    input wire                o_heater_igbt_mode,
    input wire                o_heater_sink_en,
    input wire [LS_COUNT-1:0] o_ls_sink_en
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    a_global_or: assert property ($past(i_stat_addr) != 4'he |->
        o_stat_rdata[7] == |o_stat_rdata[3:0]) else $error("global bit wrong");
    a_spare_bits: assert property ($past(i_stat_addr) != 4'he |->
        o_stat_rdata[6:4] == 3'h0) else $error("spare bits set");
    a_unused_slot: assert property ($past(i_stat_addr) inside {4'h1, [4'h8:4'hd], 4'hf}
        |-> o_stat_rdata == 8'h00) else $error("unused address not zero");
    a_tacho_no_short: assert property ($past(i_stat_addr) == 4'h4 |->
        !o_stat_rdata[0]) else $error("tacho short flag set");
    a_indicator_gaps: assert property ($past(i_stat_addr) == 4'he |->
        !o_stat_rdata[6] && !o_stat_rdata[1]) else $error("indicator gap set");
    a_mode_after_reset: assert property (!$past(i_rstn) |->
        o_ignition_igbt_mode && !o_heater_igbt_mode) else $error("reset modes wrong");
    a_ign_mode_write: assert property (i_reg_wr && i_reg_addr == 4'h8 |->
        ##2 o_ignition_igbt_mode == $past(i_reg_wdata[7], 2)) else $error("ign mode stale");
    a_htr_cfg_write: assert property (i_reg_wr && i_reg_addr == 4'h7 |-> ##2
        {o_heater_igbt_mode, o_heater_sink_en} == {$past(i_reg_wdata[7], 2),
        $past(i_reg_wdata[4], 2)}) else $error("heater config stale");
    a_ls_sink_write: assert property (i_reg_wr && i_reg_addr == 4'ha |->
        ##2 o_ls_sink_en == $past(i_reg_wdata[4:0], 2)) else $error("sink enables stale");

    c_tacho_fault: cover property ($past(i_stat_addr) == 4'h4 && o_stat_rdata[7]);
    c_ign_on: cover property ($past(i_stat_addr) == 4'he && o_stat_rdata[2]);
    c_ign_cfg: cover property (i_reg_wr && i_reg_addr == 4'h8);
endmodule

bind dfs_status_bank dfs_status_bank_checker #(.LS_COUNT(LS_COUNT)) i_dfs_status_bank_checker (
    .i_core_clk, .i_rstn, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_stat_addr, .o_stat_rdata,
    .o_ignition_igbt_mode, .o_heater_igbt_mode, .o_heater_sink_en, .o_ls_sink_en);

/* verif/dfs_status_bank_test.sv */
`timescale 1ns/10ps

`define CHK(n, e, g) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
    n_fail = n_fail + 1; $display("unexpected %0s exp %h got %h", n, e, g); end end

module dfs_status_bank_test;
    localparam [19:0] LS_ADDR = 20'h54320; // Status address per driver.
    reg        i_core_clk = 1'h0;
    reg        i_rstn = 1'h0;
    reg        i_reg_wr = 1'h0;
    reg  [3:0] i_reg_addr = 4'h0;
    reg  [7:0] i_reg_wdata = 8'h00;
    reg  [3:0] i_stat_addr = 4'h0;
    reg  [4:0] flt [0:3];        // Comparators: short, overtemp, overcurrent, open load.
    reg  [4:0] on_st = 5'h00;    // Low-side outputs actually on.
    reg  [3:0] fbk = 4'h2;       // Heater sense, ignition sense, heater drain, ignition drain.
    reg  [3:0] hp = 4'h0;        // Heater level, heater drive, ignition level, ignition drive.
    wire [7:0] o_stat_rdata;
    wire       ign_gate, htr_gate, ign_mode, htr_mode, ign_sink, htr_sink, ign_pin, htr_pin;
    wire [4:0] ls_sink;
    integer    n_fail = 0, samples_checked = 0, d, f, k;
    reg  [3:0] e;

    dfs_host_model i_dfs_host_model (.i_ign_drive(hp[0]), .i_ign_level(hp[1]),
        .i_htr_drive(hp[2]), .i_htr_level(hp[3]), .o_ign_pin(ign_pin), .o_htr_pin(htr_pin));
    dfs_status_bank i_dfs_status_bank (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_stat_addr(i_stat_addr), .o_stat_rdata(o_stat_rdata), .i_ls_open_load(flt[3]),
        .i_ls_overcurrent(flt[2]), .i_ls_overtemp(flt[1]), .i_ls_short_gnd(flt[0]),
        .i_ls_on_state(on_st), .i_ignition_control_input(ign_pin),
        .i_heater_control_input(htr_pin), .i_ignition_drain_feedback(fbk[0]),
        .i_heater_drain_feedback(fbk[1]), .i_ignition_sense_over(fbk[2]),
        .i_heater_sense_over(fbk[3]), .o_ignition_gate_output(ign_gate),
        .o_heater_gate_output(htr_gate), .o_ignition_igbt_mode(ign_mode),
        .o_heater_igbt_mode(htr_mode), .o_ignition_sink_en(ign_sink),
        .o_heater_sink_en(htr_sink), .o_ls_sink_en(ls_sink));

    // Clock and watchdog; a hang fails the run.
    always #2 i_core_clk = ~i_core_clk;
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_fail = n_fail + 1;
        test_done;
    end

    // One configuration write, strobe high for one edge.
    task wr(input [3:0] a, input [7:0] dat);
        begin
            @(posedge i_core_clk);
            i_reg_wr    <= 1'h1;
            i_reg_addr  <= a;
            i_reg_wdata <= dat;
            @(posedge i_core_clk);
            i_reg_wr    <= 1'h0;
        end
    endtask
    // Covers two synchroniser edges and the register stages.
    task settle;
        begin
            repeat (6) @(posedge i_core_clk);
            #1;
        end
    endtask
    task rd(input [3:0] a, input [7:0] ex);
        begin
            @(posedge i_core_clk);
            i_stat_addr <= a;
            settle;
            `CHK("status byte", ex, o_stat_rdata)
        end
    endtask
    task test_done;
        begin
            $display("checks %0d failures %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        for (k = 0; k < 4; k = k + 1)
            flt[k] = 5'h00;
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'h1;
        settle;
        `CHK("modes", 2'h2, {ign_mode, htr_mode})
        `CHK("sinks", 7'h3f, {ign_sink, htr_sink, ls_sink})
        for (k = 0; k < 16; k = k + 1)
            if (k != 6 && k != 7)
                rd(k[3:0], 8'h00);
        $display("test reset done");
        // Each flag alone, then all four, on every low-side driver.
        for (d = 0; d < 5; d = d + 1) begin
            for (f = 0; f < 5; f = f + 1) begin
                @(posedge i_core_clk);
                for (k = 0; k < 4; k = k + 1)
                    flt[k] <= (k == f || f == 4) ? 5'h01 << d : 5'h00;
                e = (f == 4) ? 4'hf : 4'h1 << f;
                if (d == 3)
                    e[0] = 1'b0;
                rd(LS_ADDR[d*4 +: 4], {|e, 3'h0, e});
            end
        end
        $display("test driver faults done");
        @(posedge i_core_clk);
        flt[3] <= 5'h1f;
        flt[2] <= 5'h00;
        flt[1] <= 5'h00;
        flt[0] <= 5'h00;
        wr(4'ha, 8'h1e);
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h88);
        @(posedge i_core_clk);
        on_st <= 5'h04;
        rd(4'h3, 8'h00);
        $display("test open load done");
        @(posedge i_core_clk);
        flt[3] <= 5'h00;
        on_st <= 5'h08;
        rd(4'he, 8'h00);
        @(posedge i_core_clk);
        on_st <= 5'h17;
        rd(4'he, 8'hb8);
        @(posedge i_core_clk);
        hp <= 4'h3;
        rd(4'he, 8'hbc);
        @(posedge i_core_clk);
        hp <= 4'hf;
        rd(4'he, 8'hbd);
        @(posedge i_core_clk);
        hp <= 4'h0;
        settle;
        `CHK("gates", 2'h0, {ign_gate, htr_gate})
        wr(4'h8, 8'h84);
        @(posedge i_core_clk);
        hp <= 4'h3;
        settle;
        `CHK("and gate", 1'h0, ign_gate)
        wr(4'h0, 8'h04);
        settle;
        `CHK("and gate", 1'h1, ign_gate)
        wr(4'h8, 8'hff);
        settle;
        `CHK("ign cfg", 2'h3, {ign_mode, ign_sink})
        wr(4'h8, 8'h00);
        wr(4'h7, 8'h80);
        settle;
        `CHK("modes", 3'h2, {ign_mode, htr_mode, htr_sink})
        $display("test gates done");
        @(posedge i_core_clk);
        fbk <= 4'h3;
        rd(4'h6, 8'h84);
        @(posedge i_core_clk);
        fbk <= 4'h6;
        rd(4'h6, 8'h84);
        @(posedge i_core_clk);
        fbk <= 4'h8;
        rd(4'h7, 8'h84);
        wr(4'h7, 8'h10);
        @(posedge i_core_clk);
        fbk <= 4'h0;
        rd(4'h7, 8'h88);
        @(posedge i_core_clk);
        hp <= 4'hf;
        rd(4'h7, 8'h00);
        $display("test pre-driver faults done");
        test_done;
    end
endmodule
